/* ccrb_pkg.sv */
// constants and carrier types for the coulomb counter register bank
// assumes a 25 MHz system clock and byte-wide register access
`default_nettype none

package ccrb_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    // one duration-timer step at the fast rate, 1/4096 hour
    localparam int BASE_TICK_NS   = 878906250;
    localparam int BASE_TICK_US   = 878906;
    localparam int BASE_TICK_CYC  = BASE_TICK_NS / CLK_PERIOD_NS;
    localparam int HOUR_TICKS     = 4096;
    localparam int FAST_PER_HOUR  = 4096;
    localparam int SLOW_PER_HOUR  = 16;
    localparam int SLOW_DIV       = FAST_PER_HOUR / SLOW_PER_HOUR;
    localparam int WAKE_WIN_MS    = 4000;
    localparam int WAKE_WIN_TICKS = (WAKE_WIN_MS * 1000) / BASE_TICK_US;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 9;
    localparam logic [8:0]  A_TEMP_LO   = 9'h102;
    localparam logic [8:0]  A_TEMP_HI   = 9'h103;
    localparam logic [8:0]  A_CLR       = 9'h104;
    localparam logic [8:0]  A_MODE      = 9'h105;
    localparam logic [8:0]  A_CTIME_LO  = 9'h106;
    localparam logic [8:0]  A_CTIME_HI  = 9'h107;
    localparam logic [8:0]  A_DTIME_LO  = 9'h108;
    localparam logic [8:0]  A_DTIME_HI  = 9'h109;
    localparam logic [8:0]  A_SD_LO     = 9'h10A;
    localparam logic [8:0]  A_SD_HI     = 9'h10B;
    localparam logic [8:0]  A_CHG_LO    = 9'h10C;
    localparam logic [8:0]  A_CHG_HI    = 9'h10D;
    localparam logic [8:0]  A_DSG_LO    = 9'h10E;
    localparam logic [8:0]  A_DSG_HI    = 9'h10F;

    // clear register fields
    localparam int B_POR   = 6;
    localparam int B_STAT  = 5;
    localparam int B_CTC   = 4;
    localparam int B_DTC   = 3;
    localparam int B_SCR   = 2;
    localparam int B_CCR   = 1;
    localparam int B_DCR   = 0;
    // mode register fields
    localparam int B_SLEEP_ALLOW  = 6;
    localparam int B_STC   = 5;
    localparam int B_STD   = 4;
    localparam int B_WOE_H = 3;
    localparam int B_WOE_L = 1;

    localparam logic [2:0]  WOE_RST     = 3'h7;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [7:0]  RD_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // temperature banding, 0.25 K per code
    // ------------------------------------------------------------
    localparam logic [11:0] TEMP_0C_CODE  = 12'h445;
    localparam logic [11:0] TEMP_BAND_W   = 12'h028;
    localparam int          SD_BANDS      = 8;
    localparam logic [7:0]  SD_ACC_FULL   = 8'h80;

    typedef struct packed {
        logic [8:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } ccrb_req_t;

    typedef struct packed {
        logic       sleep_allow;
        logic [2:0] wake_threshold_sel;
    } ccrb_mode_t;

endpackage

`default_nettype wire

/* ccrb_bank.sv */
// coulomb counter register bank: counters, timers, sleep control
// assumes a command decoder on clk_sys_i issues byte register accesses
`default_nettype none


module ccrb_bank #(
    parameter int TICK_CYCLES = ccrb_pkg::BASE_TICK_CYC,
    parameter int HOUR_TICKS  = ccrb_pkg::HOUR_TICKS,
    parameter int SLOW_DIV    = ccrb_pkg::SLOW_DIV,
    parameter int WAKE_TICKS  = ccrb_pkg::WAKE_WIN_TICKS
) (
    // clock, reset, enable
    input  wire logic               clk_sys_i,
    input  wire logic               nrst_i,
    input  wire logic               ce_i,
    // register access
    input  wire ccrb_pkg::ccrb_req_t reg_req_i,
    output logic [7:0]              rd_data_o,
    // sense front end
    input  wire logic               vfc_tick_i,
    input  wire logic               sense_pos_gt_i,
    input  wire logic               sense_neg_gt_i,
    input  wire logic [2:0]         sense_mag_i,
    input  wire logic [11:0]        die_temp_i,
    // single-wire bus pin level
    input  wire logic               bus_pin_i,
    // status pin and power state
    output logic                    stat_o,
    output logic                    stat_oe_o,
    output logic                    sleeping_o,
    output logic                    maint_wake_o
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    // the slow divider wraps freely, so it must be a power of two
    if (TICK_CYCLES < 2 || HOUR_TICKS < 2 || SLOW_DIV < 2 ||
        SLOW_DIV > 256 || WAKE_TICKS < 1 || HOUR_TICKS > 65535 ||
        WAKE_TICKS >= HOUR_TICKS ||
        (SLOW_DIV & (SLOW_DIV - 1)) != 0) begin : g_param_check
        $error("ccrb_bank: unsupported timing parameters");
    end

    localparam int TW = $clog2(TICK_CYCLES);
    localparam int HW = $clog2(HOUR_TICKS + 1);
    localparam int SW = $clog2(SLOW_DIV);

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_SLEEP = 3'b010,
        ST_MAINT = 3'b100
    } ccrb_pwr_t;

    function automatic logic [2:0] temp_band(input logic [11:0] code);
        logic [2:0] b;
        b = 3'h0;
        for (int i = 1; i < ccrb_pkg::SD_BANDS; i++) begin
            if (code >= 12'(ccrb_pkg::TEMP_0C_CODE
                            + 12'(i - 1) * ccrb_pkg::TEMP_BAND_W))
                b = 3'(i);
        end
        return b;
    endfunction

    function automatic logic [7:0] byte_sel(input logic [15:0] v,
                                            input logic        hi);
        return hi ? v[15:8] : v[7:0];
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // bus pin idles high; resetting to that level avoids a false edge
    localparam logic [5:0] SYNC_RST = 6'h20;

    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    logic       pin_prev_ff;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_ff    <= SYNC_RST;
            sync2_ff    <= SYNC_RST;
            pin_prev_ff <= SYNC_RST[5];
        end else if (ce_i) begin
            sync1_ff    <= {bus_pin_i, sense_mag_i,
                            sense_neg_gt_i, sense_pos_gt_i};
            sync2_ff    <= sync1_ff;
            pin_prev_ff <= sync2_ff[5];
        end
    end

    wire       pos_gt   = sync2_ff[0];
    wire       neg_gt   = sync2_ff[1];
    wire [2:0] mag      = sync2_ff[4:2];
    wire       pin_edge = sync2_ff[5] ^ pin_prev_ff;
    wire       is_chg   = pos_gt & ~neg_gt;
    wire       is_dsg   = neg_gt & ~pos_gt;

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    logic [TW-1:0] tick_cnt_ff;
    logic [SW-1:0] slow_cnt_ff;
    wire           base_tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));
    wire           slow_tick = base_tick &
                               (slow_cnt_ff == SW'(SLOW_DIV - 1));

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt_ff <= '0;
            slow_cnt_ff <= '0;
        end else if (ce_i) begin
            tick_cnt_ff <= base_tick ? '0 : tick_cnt_ff + 1'b1;
            if (base_tick)
                slow_cnt_ff <= slow_cnt_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    wire       wr_clr  = reg_req_i.wr & (reg_req_i.addr == ccrb_pkg::A_CLR);
    wire       wr_mode = reg_req_i.wr &
                         (reg_req_i.addr == ccrb_pkg::A_MODE);
    wire [7:0] wd      = reg_req_i.wdata;

    // ------------------------------------------------------------
    // clear register
    // ------------------------------------------------------------
    logic [4:0] clr_pend_ff;
    logic       por_ff;
    logic       stat_bit_ff;

    // a pending clear runs on the next enabled edge; a fresh write of
    // the same bit re-arms it, so the clear is never lost
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clr_pend_ff <= 5'h00;
            por_ff      <= 1'b1;
            stat_bit_ff <= 1'b1;
        end else if (ce_i) begin
            clr_pend_ff <= wr_clr ? wd[ccrb_pkg::B_CTC:ccrb_pkg::B_DCR]
                                  : 5'h00;
            if (wr_clr && !wd[ccrb_pkg::B_POR])
                por_ff <= 1'b0;
            if (wr_clr)
                stat_bit_ff <= wd[ccrb_pkg::B_STAT];
        end
    end

    wire clr_ctime = clr_pend_ff[ccrb_pkg::B_CTC];
    wire clr_dtime = clr_pend_ff[ccrb_pkg::B_DTC];
    wire clr_sd    = clr_pend_ff[ccrb_pkg::B_SCR];
    wire clr_chg   = clr_pend_ff[ccrb_pkg::B_CCR];
    wire clr_dsg   = clr_pend_ff[ccrb_pkg::B_DCR];

    // ------------------------------------------------------------
    // mode register and power state
    // ------------------------------------------------------------
    ccrb_pkg::ccrb_mode_t mode_ff;
    ccrb_pwr_t            pwr_ff;
    ccrb_pwr_t            nxt_pwr;
    logic [HW-1:0]        idle_ff;
    logic [HW-1:0]        slp_ff;

    wire running   = (pwr_ff != ST_SLEEP);
    wire idle_done = (idle_ff == HW'(HOUR_TICKS));
    wire woe_off   = (mode_ff.wake_threshold_sel == 3'h0);
    wire low_cur   = woe_off | (mag < mode_ff.wake_threshold_sel);
    wire go_sleep  = mode_ff.sleep_allow & low_cur & idle_done;

    always_comb begin
        nxt_pwr = pwr_ff;
        case (pwr_ff)
            ST_RUN:   if (go_sleep && !pin_edge) nxt_pwr = ST_SLEEP;
            ST_SLEEP: begin
                if (pin_edge)
                    nxt_pwr = ST_RUN;
                else if (base_tick && slp_ff == HW'(HOUR_TICKS - 1))
                    nxt_pwr = ST_MAINT;
            end
            ST_MAINT: begin
                if (pin_edge)
                    nxt_pwr = ST_RUN;
                else if (base_tick && slp_ff == HW'(WAKE_TICKS - 1))
                    nxt_pwr = ST_SLEEP;
            end
            default:  nxt_pwr = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwr_ff  <= ST_RUN;
            idle_ff <= '0;
            slp_ff  <= '0;
        end else if (ce_i) begin
            pwr_ff <= nxt_pwr;
            if (pin_edge || reg_req_i.wr || reg_req_i.rd)
                idle_ff <= '0;
            else if (base_tick && !idle_done)
                idle_ff <= idle_ff + 1'b1;
            if (nxt_pwr != pwr_ff)
                slp_ff <= '0;
            else if (base_tick)
                slp_ff <= slp_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_ff.sleep_allow        <= 1'b1;
            mode_ff.wake_threshold_sel <= ccrb_pkg::WOE_RST;
        end else if (ce_i) begin
            // a wake edge in ST_SLEEP sets the enable even against a host clear; one in ST_MAINT does not
            if (pin_edge && !running)
                mode_ff.sleep_allow <= 1'b1;
            else if (wr_mode)
                mode_ff.sleep_allow <= wd[ccrb_pkg::B_SLEEP_ALLOW];
            if (wr_mode)
                mode_ff.wake_threshold_sel <=
                    wd[ccrb_pkg::B_WOE_H:ccrb_pkg::B_WOE_L];
        end
    end

    // ------------------------------------------------------------
    // charge and discharge counts
    // ------------------------------------------------------------
    logic [15:0] chg_cnt_ff;
    logic [15:0] dsg_cnt_ff;
    wire         vfc_on = running & vfc_tick_i;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chg_cnt_ff <= 16'h0000;
            dsg_cnt_ff <= 16'h0000;
        end else if (ce_i) begin
            if (clr_chg)
                chg_cnt_ff <= 16'h0000;
            else if (vfc_on && is_chg)
                chg_cnt_ff <= chg_cnt_ff + 16'h0001;
            if (clr_dsg)
                dsg_cnt_ff <= 16'h0000;
            else if (vfc_on && is_dsg)
                dsg_cnt_ff <= dsg_cnt_ff + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // duration timers and rollover flags
    // ------------------------------------------------------------
    logic [15:0] ctime_ff;
    logic [15:0] dtime_ff;
    logic        slow_chg_ff;
    logic        slow_dsg_ff;

    wire c_step = running & is_chg &
                  (slow_chg_ff ? slow_tick : base_tick);
    wire d_step = running & is_dsg &
                  (slow_dsg_ff ? slow_tick : base_tick);
    wire c_roll = c_step & (ctime_ff == ccrb_pkg::CNT_MAX);
    wire d_roll = d_step & (dtime_ff == ccrb_pkg::CNT_MAX);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctime_ff <= 16'h0000;
            dtime_ff <= 16'h0000;
        end else if (ce_i) begin
            if (clr_ctime)
                ctime_ff <= 16'h0000;
            else if (c_step)
                ctime_ff <= ctime_ff + 16'h0001;
            if (clr_dtime)
                dtime_ff <= 16'h0000;
            else if (d_step)
                dtime_ff <= dtime_ff + 16'h0001;
        end
    end

    // no reset on purpose: these flags power up undefined
    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            if (clr_ctime)
                slow_chg_ff <= 1'b0;
            else if (c_roll)
                slow_chg_ff <= ~slow_chg_ff;
            if (clr_dtime)
                slow_dsg_ff <= 1'b0;
            else if (d_roll)
                slow_dsg_ff <= ~slow_dsg_ff;
        end
    end

    // ------------------------------------------------------------
    // self-drain count
    // ------------------------------------------------------------
    logic [7:0]  sd_acc_ff;
    logic [4:0]  sd_pend_ff;
    logic [15:0] sd_cnt_ff;
    wire  [2:0]  band    = temp_band(die_temp_i);
    wire  [8:0]  sd_sum  = {1'b0, sd_acc_ff} + (9'h001 << band);
    wire         sd_step = slow_tick & (sd_sum >= {1'b0, ccrb_pkg::SD_ACC_FULL});
    wire         sd_hold = (pwr_ff == ST_SLEEP);

    // asleep, steps are held and applied when sleep ends, in the hourly window or on a wake edge
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sd_acc_ff  <= 8'h00;
            sd_pend_ff <= 5'h00;
            sd_cnt_ff  <= 16'h0000;
        end else if (ce_i) begin
            if (slow_tick)
                sd_acc_ff <= sd_step
                           ? 8'(sd_sum - {1'b0, ccrb_pkg::SD_ACC_FULL})
                           : sd_sum[7:0];
            if (clr_sd) begin
                sd_cnt_ff  <= 16'h0000;
                sd_pend_ff <= 5'h00;
            end else if (sd_hold) begin
                if (sd_step)
                    sd_pend_ff <= sd_pend_ff + 5'h01;
            end else begin
                sd_cnt_ff  <= sd_cnt_ff + 16'(sd_pend_ff)
                              + 16'(sd_step);
                sd_pend_ff <= 5'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire [7:0] clr_view  = {1'b0, por_ff, stat_bit_ff, clr_pend_ff};
    wire [7:0] mode_view = {1'b0, mode_ff.sleep_allow, slow_chg_ff,
                            slow_dsg_ff, mode_ff.wake_threshold_sel,
                            1'b0};
    wire       hi        = reg_req_i.addr[0];
    logic [7:0] rd_mux;

    always_comb begin
        case (reg_req_i.addr)
            ccrb_pkg::A_TEMP_LO,
            ccrb_pkg::A_TEMP_HI:  rd_mux = byte_sel({4'h0, die_temp_i}, hi);
            ccrb_pkg::A_CLR:      rd_mux = clr_view;
            ccrb_pkg::A_MODE:     rd_mux = mode_view;
            ccrb_pkg::A_CTIME_LO,
            ccrb_pkg::A_CTIME_HI: rd_mux = byte_sel(ctime_ff, hi);
            ccrb_pkg::A_DTIME_LO,
            ccrb_pkg::A_DTIME_HI: rd_mux = byte_sel(dtime_ff, hi);
            ccrb_pkg::A_SD_LO,
            ccrb_pkg::A_SD_HI:    rd_mux = byte_sel(sd_cnt_ff, hi);
            ccrb_pkg::A_CHG_LO,
            ccrb_pkg::A_CHG_HI:   rd_mux = byte_sel(chg_cnt_ff, hi);
            ccrb_pkg::A_DSG_LO,
            ccrb_pkg::A_DSG_HI:   rd_mux = byte_sel(dsg_cnt_ff, hi);
            default:              rd_mux = ccrb_pkg::RD_UNMAPPED;
        endcase
    end

    // temperature is read live from the sensor code
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_o    <= 8'h00;
            stat_o       <= 1'b0;
            stat_oe_o    <= 1'b0;
            sleeping_o   <= 1'b0;
            maint_wake_o <= 1'b0;
        end else if (ce_i) begin
            if (reg_req_i.rd)
                rd_data_o <= rd_mux;
            stat_oe_o    <= ~stat_bit_ff;
            sleeping_o   <= (nxt_pwr == ST_SLEEP);
            maint_wake_o <= (nxt_pwr == ST_MAINT);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    a_chg_count_step: assert property (
        ce_i && vfc_on && is_chg && !clr_chg
        |=> chg_cnt_ff == 16'($past(chg_cnt_ff) + 16'h0001))
        else $error("charge count did not step");

    a_dsg_count_step: assert property (
        ce_i && vfc_on && is_dsg && !clr_dsg
        |=> dsg_cnt_ff == 16'($past(dsg_cnt_ff) + 16'h0001))
        else $error("discharge count did not step");

    a_equal_no_move: assert property (
        ce_i && (pos_gt == neg_gt) && !(|clr_pend_ff)
        |=> $stable(chg_cnt_ff) && $stable(dsg_cnt_ff) &&
            $stable(ctime_ff) && $stable(dtime_ff))
        else $error("counter moved with equal sense inputs");

    a_dsg_roll_flag: assert property (
        ce_i && d_roll && !clr_dtime
        |=> dtime_ff == 16'h0000 && slow_dsg_ff != $past(slow_dsg_ff))
        else $error("discharge rollover mishandled");

    a_clr_two_cycle: assert property (
        ce_i && wr_clr && wd[ccrb_pkg::B_CCR]
        ##1 ce_i && !(wr_clr && wd[ccrb_pkg::B_CCR])
        |=> chg_cnt_ff == 16'h0000 && !clr_pend_ff[ccrb_pkg::B_CCR])
        else $error("charge count clear did not complete");

    a_por_write_one: assert property (
        ce_i && wr_clr && wd[ccrb_pkg::B_POR] |=> por_ff == $past(por_ff))
        else $error("power-on flag changed on write of one");

    a_stat_pin_follow: assert property (
        ce_i ##1 ce_i |=> stat_oe_o == !$past(stat_bit_ff))
        else $error("status pin does not follow its bit");

    a_sleep_entry: assert property (
        ce_i && pwr_ff == ST_RUN && nxt_pwr == ST_SLEEP
        |-> mode_ff.sleep_allow && idle_done && low_cur)
        else $error("sleep entered without its conditions");

    a_wake_on_edge: assert property (
        ce_i && !running && pin_edge
        |=> pwr_ff == ST_RUN && mode_ff.sleep_allow)
        else $error("bus edge did not wake the device");

    a_rsvd_mode_zero: assert property (
        ce_i && reg_req_i.rd && reg_req_i.addr == ccrb_pkg::A_MODE
        |=> rd_data_o[7] == 1'b0 && rd_data_o[0] == 1'b0)
        else $error("reserved mode bits read nonzero");

endmodule

`default_nettype wire

/* ccrb_host.sv */
// host model: byte register requests to the bank
// assumes the bench owns the clock
`default_nettype none
module ccrb_host (
    // clock and read data
    input  wire logic           clk_sys_i,
    input  wire logic [7:0]     rd_data_i,
    // request
    output var ccrb_pkg::ccrb_req_t req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req_o = '0;
    // ----
    // access tasks
    // ----
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req_o <= {a, 2'b10, (a == 9'h105) ? d & 8'h7E : d};
        @(posedge clk_sys_i);
        req_o.wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        req_o <= {a, 2'b01, 8'h00};
        @(posedge clk_sys_i);
        req_o.rd <= 1'b0;
        // data lands on the taking edge, let it settle
        #1 d = rd_data_i;
    endtask
endmodule
`default_nettype wire

/* coulomb_counter_register_bank_bench.sv */
// bench for the coulomb counter register bank
// assumes short tick parameters; sleep is disabled early
`default_nettype none
module coulomb_counter_register_bank_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                clk_sys_i, nrst_i, tick, pos_gt, neg_gt, stat_oe;
    logic [7:0]          rd_data, d;
    logic                ce, pin, stat_pin, sleeping, maint;
    logic [11:0]         temp;
    ccrb_pkg::ccrb_req_t req;
    int                  mismatches, total_checks;
    ccrb_bank #(.TICK_CYCLES(4), .HOUR_TICKS(8), .SLOW_DIV(4),
        .WAKE_TICKS(2)) i_ccrb_bank (.clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i), .ce_i(ce), .reg_req_i(req),
        .rd_data_o(rd_data), .vfc_tick_i(tick), .sense_pos_gt_i(pos_gt),
        .sense_neg_gt_i(neg_gt), .sense_mag_i(3'h0),
        .die_temp_i(temp), .bus_pin_i(pin), .stat_o(stat_pin),
        .stat_oe_o(stat_oe), .sleeping_o(sleeping), .maint_wake_o(maint));
    ccrb_host i_ccrb_host (.clk_sys_i(clk_sys_i), .rd_data_i(rd_data),
        .req_o(req));
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(logic [8:0] a, logic [7:0] m, e, string n);
        i_ccrb_host.rd(a, d);
        chk(n, d & m, e);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // whole run is a few hundred cycles
    initial begin
        #200000;
        mismatches++;
        results();
    end
    // ----
    // tests
    // ----
    initial begin
        {nrst_i, tick, pos_gt, neg_gt} = 4'h0;
        {ce, pin, temp} = {2'b11, 12'h4A8};
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rc(9'h104, 8'hFF, 8'h60, "clear");
        chk("stat_oe", {7'h0, stat_oe}, 8'h00);
        // rollover flags unreset, masked out
        rc(9'h105, 8'hCF, 8'h4E, "mode");
        i_ccrb_host.wr(9'h105, 8'h00);
        rc(9'h105, 8'hCF, 8'h00, "mode");
        i_ccrb_host.wr(9'h104, 8'h40);
        rc(9'h104, 8'hFF, 8'h40, "clear");
        chk("stat_oe", {7'h0, stat_oe}, 8'h01);
        i_ccrb_host.wr(9'h104, 8'h20);
        rc(9'h104, 8'hFF, 8'h20, "clear");
        rc(9'h102, 8'hFF, 8'hA8, "temp lo");
        rc(9'h103, 8'hFF, 8'h04, "temp hi");
        @(posedge clk_sys_i) temp <= 12'h3FF;
        rc(9'h102, 8'hFF, 8'hFF, "temp lo");
        rc(9'h103, 8'hFF, 8'h03, "temp hi");
        rc(9'h100, 8'hFF, 8'h00, "unmapped");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys_i) pos_gt <= (i == 0);
            neg_gt <= (i == 1);
            repeat (3) @(posedge clk_sys_i);
            tick <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
            tick <= 1'b0;
            rc(9'h10C, 8'hFF, i ? 8'h00 : 8'h03, "chg");
            rc(9'h10E, 8'hFF, i == 1 ? 8'h03 : 8'h00, "dsg");
            i_ccrb_host.wr(9'h104, 8'h23);
            rc(i ? 9'h10E : 9'h10C, 8'hFF, 8'h00, "zero");
            rc(9'h104, 8'hFF, 8'h20, "clear");
        end
        // counting frozen while the enable is low
        @(posedge clk_sys_i) pos_gt <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        {ce, tick} <= 2'b01;
        repeat (3) @(posedge clk_sys_i);
        {ce, tick, pos_gt} <= 3'b100;
        rc(9'h10C, 8'hFF, 8'h00, "chg frozen");
        chk("stat", {7'h0, stat_pin}, 8'h00);
        i_ccrb_host.wr(9'h104, 8'h3C);
        rc(9'h104, 8'hFF, 8'h20, "clear");
        rc(9'h106, 8'hFF, 8'h00, "ctime");
        rc(9'h108, 8'hFF, 8'h00, "dtime");
        rc(9'h10A, 8'hFF, 8'h00, "sd");
        rc(9'h105, 8'hFF, 8'h00, "mode");
        // idle with sleep allowed and the threshold off
        i_ccrb_host.wr(9'h105, 8'h40);
        repeat (50) @(posedge clk_sys_i);
        chk("sleeping", {7'h0, sleeping}, 8'h01);
        for (int k = 0; k < 40 && !maint; k++) @(posedge clk_sys_i);
        chk("maint", {7'h0, maint}, 8'h01);
        for (int k = 0; k < 20 && maint; k++) @(posedge clk_sys_i);
        pin <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        chk("sleeping", {7'h0, sleeping}, 8'h00);
        chk("maint", {7'h0, maint}, 8'h00);
        rc(9'h105, 8'hFF, 8'h40, "mode");
        // second power-on in mid-run
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rc(9'h104, 8'hFF, 8'h60, "clear");
        rc(9'h105, 8'hFF, 8'h4E, "mode");
        results();
    end
endmodule
`default_nettype wire
